// File: vectored_int_pkg.sv
// constants, field layouts and types shared by the vectored interrupt unit
// assumes one 25 MHz system clock and a synchronous active-high reset
package vectored_int_pkg;

  // sources and program memory layout
  localparam int NUM_SRC = 4;
  localparam int PC_W    = 14;
  localparam int OFF_W   = 7;
  localparam int PAGE_W  = PC_W - OFF_W;
  localparam int ROM_WORD_W = 10;
  localparam int CTX_W   = 24;

  localparam logic [PAGE_W-1:0] VEC_PAGE      = 7'h01;
  localparam logic [OFF_W-1:0]  VEC_OFF_EXT   = 7'h00;
  localparam logic [OFF_W-1:0]  VEC_OFF_TMR_A = 7'h04;
  localparam logic [OFF_W-1:0]  VEC_OFF_TMR_B = 7'h06;
  localparam logic [OFF_W-1:0]  VEC_OFF_TMR_C = 7'h08;

  // source index, also the priority rank (lower wins)
  localparam logic [1:0] SRC_EXT   = 2'h0;
  localparam logic [1:0] SRC_TMR_A = 2'h1;
  localparam logic [1:0] SRC_TMR_B = 2'h2;
  localparam logic [1:0] SRC_TMR_C = 2'h3;

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL_LOW  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EV_STAT   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EV_MASK   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CONTEXT   = 8'h14;

  // field positions
  localparam int CTRL_W        = 4;
  localparam int LOW_EXT_BIT   = 0;
  localparam int LOW_TMR_A_BIT = 2;
  localparam int LOW_TMR_B_BIT = 3;
  localparam int HIGH_TMR_C_BIT = 0;
  localparam int FLG_W         = 7;
  localparam int FLG_DROP_BIT  = 4;
  localparam int FLG_GIE_BIT   = 5;
  localparam int FLG_EIP_BIT   = 6;
  localparam int EV_W          = 6;
  localparam int EV_TAKEN_BIT  = 4;
  localparam int EV_DROP_BIT   = 5;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [EV_W-1:0]   EV_RST   = 6'h00;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_ENTRY = 2'b10
  } seq_state_e;

endpackage

// File: pin_event_sync.sv
// three-stage synchroniser with a debounced level and a change pulse
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ns
module pin_event_sync
  import vectored_int_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // pin and result
  input  wire logic pin_i,
  output logic      level_o,
  output logic      change_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic primed_reg;
  logic [2:0] fill_reg;
  logic agree;

  // first stage feeds the second only
  assign agree    = (s2_reg == s3_reg);
  assign change_o = agree & primed_reg & (s3_reg != level_reg);
  assign level_o  = level_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_reg     <= 1'b0;
      s2_reg     <= 1'b0;
      s3_reg     <= 1'b0;
      level_reg  <= 1'b0;
      primed_reg <= 1'b0;
      fill_reg   <= 3'h0;
    end else begin
      s1_reg   <= pin_i;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      fill_reg <= {fill_reg[1:0], 1'b1};
      // stages hold reset zeros at first; a high pin would look like a
      // change, so the first real settled level is taken without an event
      if (agree & fill_reg[2]) begin
        level_reg  <= s3_reg;
        primed_reg <= 1'b1;
      end
    end
  end

endmodule

// File: src_priority_pick.sv
// fixed-priority pick over the eligible sources, with vector lookup
// assumes bit 0 is the highest priority source
`timescale 1ns/1ns
module src_priority_pick
  import vectored_int_pkg::*;
(
  // eligible requests
  input  wire logic [NUM_SRC-1:0] elig_i,
  // selection
  output logic                    any_o,
  output logic [NUM_SRC-1:0]      grant_o,
  output logic [OFF_W-1:0]        offset_o
);

  logic [NUM_SRC-1:0] lower_busy;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_pick
      if (g == 0) begin : g_first
        assign lower_busy[g] = 1'b0;
      end else begin : g_rest
        assign lower_busy[g] = lower_busy[g-1] | elig_i[g-1];
      end
      assign grant_o[g] = elig_i[g] & ~lower_busy[g];
    end
  endgenerate

  assign any_o    = |elig_i;
  assign offset_o = grant_o[SRC_EXT]   ? VEC_OFF_EXT :
                    grant_o[SRC_TMR_A] ? VEC_OFF_TMR_A :
                    grant_o[SRC_TMR_B] ? VEC_OFF_TMR_B :
                                         VEC_OFF_TMR_C;

endmodule

// File: vectored_interrupt_unit.sv
// vectored interrupt unit for a 4-bit core: request flags, enables,
// global enable, fixed priority, vector load and context save.
// assumes the sequencer pulses instr_done_i at each instruction boundary
// and then waits one cycle for int_take_o before fetching.
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
module vectored_interrupt_unit
  import vectored_int_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  // event sources
  input  wire logic              ext_event_pin_i,
  input  wire logic              supply_drop_pin_i,
  input  wire logic              tmr_a_underflow_i,
  input  wire logic              tmr_b_underflow_i,
  input  wire logic              tmr_c_underflow_i,
  // instruction sequencer requests
  input  wire logic              instr_done_i,
  input  wire logic              enable_all_instr_i,
  input  wire logic              disable_all_instr_i,
  input  wire logic              skip_test_i,
  input  wire logic [1:0]        skip_src_i,
  input  wire logic              return_from_int_instr_i,
  input  wire logic [PC_W-1:0]   pc_i,
  input  wire logic [CTX_W-1:0]  ctx_i,
  // instruction sequencer answers
  output logic                   int_take_o,
  output logic      [PC_W-1:0]   program_counter_o,
  output logic                   stack_push_o,
  output logic      [PC_W-1:0]   call_stack_entry_o,
  output logic      [CTX_W-1:0]  context_save_reg_o,
  output logic                   ctx_restore_o,
  output logic                   skip_valid_o,
  output logic                   skip_o,
  // interrupt to the host
  output logic                   irq_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  seq_state_e state_reg;
  seq_state_e state_next;

  logic [CTRL_W-1:0]  int_ctrl_low_reg;
  logic [CTRL_W-1:0]  int_ctrl_high_reg;
  logic [NUM_SRC-1:0] flag_reg;
  logic [NUM_SRC-1:0] flag_next;
  logic               drop_flag_reg;
  logic               drop_flag_next;
  logic               global_int_enable_reg;
  logic               global_int_enable_next;
  logic               ei_pend_reg;
  logic               ei_pend_next;
  logic [EV_W-1:0]    ev_stat_reg;
  logic [EV_W-1:0]    ev_stat_next;
  logic [EV_W-1:0]    ev_mask_reg;

  logic               int_take_reg;
  logic [PC_W-1:0]    pc_vec_reg;
  logic               push_reg;
  logic [PC_W-1:0]    ret_addr_reg;
  logic [CTX_W-1:0]   ctx_save_reg;
  logic               restore_reg;
  logic               skip_valid_reg;
  logic               skip_reg;
  logic               irq_reg;
  logic               ack_reg;
  logic [DATA_W-1:0]  dat_reg;

  logic               ext_event_req_flag;
  logic               tmr_a_req_flag;
  logic               tmr_b_req_flag;
  logic               tmr_c_req_flag;

  logic               ext_level;
  logic               ext_change;
  logic               drop_level;

  logic [NUM_SRC-1:0] src_set;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] grant;
  logic [NUM_SRC-1:0] take_clr;
  logic [NUM_SRC-1:0] skip_clr;
  logic               any_elig;
  logic [OFF_W-1:0]   vec_off;
  logic [PC_W-1:0]    vec_addr;
  logic               take;
  logic               boundary;
  logic               skip_fire;
  logic               skip_hit;
  logic               drop_clr;
  logic [EV_W-1:0]    ev_set;
  logic [EV_W-1:0]    ev_clr;

  logic               bus_req;
  logic               ack_next;
  logic               wr_commit;
  logic               hit_low;
  logic               hit_high;
  logic               hit_flags;
  logic               hit_stat;
  logic               hit_mask;
  logic               hit_ctx;
  logic [DATA_W-1:0]  rd_mux;
  logic [FLG_W-1:0]   flags_view;

  // ---------------------------------------------------------------
  // source front ends
  // ---------------------------------------------------------------
  pin_event_sync u_ext_sync (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .pin_i    (ext_event_pin_i),
    .level_o  (ext_level),
    .change_o (ext_change)
  );

  // supply drop is a level; only its settled value is used
  pin_event_sync u_drop_sync (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .pin_i    (supply_drop_pin_i),
    .level_o  (drop_level),
    .change_o ()
  );

  // timers share this clock, so their underflow pulses need no sync
  assign src_set = {tmr_c_underflow_i, tmr_b_underflow_i,
                    tmr_a_underflow_i, ext_change};

  assign src_en = {int_ctrl_high_reg[HIGH_TMR_C_BIT],
                   int_ctrl_low_reg[LOW_TMR_B_BIT],
                   int_ctrl_low_reg[LOW_TMR_A_BIT],
                   int_ctrl_low_reg[LOW_EXT_BIT]};

  assign ext_event_req_flag = flag_reg[SRC_EXT];
  assign tmr_a_req_flag     = flag_reg[SRC_TMR_A];
  assign tmr_b_req_flag     = flag_reg[SRC_TMR_B];
  assign tmr_c_req_flag     = flag_reg[SRC_TMR_C];

  // ---------------------------------------------------------------
  // acceptance and priority
  // ---------------------------------------------------------------
  assign elig = flag_reg & src_en;

  src_priority_pick u_pick (
    .elig_i   (elig),
    .any_o    (any_elig),
    .grant_o  (grant),
    .offset_o (vec_off)
  );

  assign vec_addr = {VEC_PAGE, vec_off};
  assign boundary = instr_done_i & (state_reg == ST_RUN);

  // a disable-all finishing at this boundary already blocks the take
  assign take = boundary & global_int_enable_reg & any_elig
              & ~disable_all_instr_i;

  assign take_clr = grant & {NUM_SRC{take}};

  // skip tests only count for sources left to polling
  assign skip_fire = boundary & skip_test_i;
  assign skip_hit  = flag_reg[skip_src_i] & ~src_en[skip_src_i];

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_flag
      assign skip_clr[g] = skip_fire & (skip_src_i == 2'(g))
                         & ~src_en[g];
      // a new event in the clearing cycle wins
      assign flag_next[g] = src_set[g]
                          | (flag_reg[g] & ~(take_clr[g] | skip_clr[g]));
    end
  endgenerate

  // ---------------------------------------------------------------
  // supply-drop flag: polled through the flags register
  // ---------------------------------------------------------------
  assign drop_clr = wr_commit & hit_flags & wb_dat_i[FLG_DROP_BIT];
  assign drop_flag_next = drop_level
                        | (drop_flag_reg & ~drop_clr);

  // ---------------------------------------------------------------
  // global enable with one-instruction delay on enable-all
  // ---------------------------------------------------------------
  assign global_int_enable_next =
      take                               ? 1'b0 :
      (boundary & disable_all_instr_i)   ? 1'b0 :
      (boundary & enable_all_instr_i)    ? global_int_enable_reg :
      (boundary & ei_pend_reg)           ? 1'b1 :
                                           global_int_enable_reg;

  assign ei_pend_next =
      take                               ? 1'b0 :
      (boundary & disable_all_instr_i)   ? 1'b0 :
      (boundary & enable_all_instr_i)    ? 1'b1 :
      boundary                           ? 1'b0 :
                                           ei_pend_reg;

  // ---------------------------------------------------------------
  // entry sequencing
  // ---------------------------------------------------------------
  always_comb begin
    case (state_reg)
      ST_RUN: begin
        state_next = take ? ST_ENTRY : ST_RUN;
      end
      ST_ENTRY: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // event status, mask and interrupt line
  // ---------------------------------------------------------------
  assign ev_set = {drop_level & ~drop_flag_reg, take, src_set};
  assign ev_clr = (wr_commit & hit_stat) ? wb_dat_i[EV_W-1:0] : EV_RST;
  assign ev_stat_next = ev_set | (ev_stat_reg & ~ev_clr);

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  assign bus_req   = wb_cyc_i & wb_stb_i;
  assign ack_next  = bus_req & ~ack_reg;
  // writes land on the edge where the master sees ack
  assign wr_commit = bus_req & wb_we_i & ack_reg & wb_sel_i[0];

  assign hit_low   = (wb_adr_i == OFS_CTRL_LOW);
  assign hit_high  = (wb_adr_i == OFS_CTRL_HIGH);
  assign hit_flags = (wb_adr_i == OFS_FLAGS);
  assign hit_stat  = (wb_adr_i == OFS_EV_STAT);
  assign hit_mask  = (wb_adr_i == OFS_EV_MASK);
  assign hit_ctx   = (wb_adr_i == OFS_CONTEXT);

  assign flags_view = {ei_pend_reg, global_int_enable_reg, drop_flag_reg,
                       tmr_c_req_flag, tmr_b_req_flag, tmr_a_req_flag,
                       ext_event_req_flag};

  assign rd_mux =
      hit_low   ? {{(DATA_W-CTRL_W){1'b0}}, int_ctrl_low_reg}  :
      hit_high  ? {{(DATA_W-CTRL_W){1'b0}}, int_ctrl_high_reg} :
      hit_flags ? {{(DATA_W-FLG_W){1'b0}}, flags_view}         :
      hit_stat  ? {{(DATA_W-EV_W){1'b0}}, ev_stat_reg}         :
      hit_mask  ? {{(DATA_W-EV_W){1'b0}}, ev_mask_reg}         :
      hit_ctx   ? {{(DATA_W-CTX_W){1'b0}}, ctx_save_reg}       :
                  {DATA_W{1'b0}};

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg             <= ST_RUN;
      flag_reg              <= {NUM_SRC{1'b0}};
      drop_flag_reg         <= 1'b0;
      global_int_enable_reg <= 1'b0;
      ei_pend_reg           <= 1'b0;
    end else begin
      state_reg             <= state_next;
      flag_reg              <= flag_next;
      drop_flag_reg         <= drop_flag_next;
      global_int_enable_reg <= global_int_enable_next;
      ei_pend_reg           <= ei_pend_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      int_ctrl_low_reg  <= CTRL_RST;
      int_ctrl_high_reg <= CTRL_RST;
      ev_stat_reg       <= EV_RST;
      ev_mask_reg       <= EV_RST;
    end else begin
      if (wr_commit & hit_low) begin
        int_ctrl_low_reg <= wb_dat_i[CTRL_W-1:0];
      end
      if (wr_commit & hit_high) begin
        int_ctrl_high_reg <= wb_dat_i[CTRL_W-1:0];
      end
      if (wr_commit & hit_mask) begin
        ev_mask_reg <= wb_dat_i[EV_W-1:0];
      end
      ev_stat_reg <= ev_stat_next;
    end
  end

  // entry outputs: vector, stack push and context capture together
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      int_take_reg <= 1'b0;
      push_reg     <= 1'b0;
      pc_vec_reg   <= {PC_W{1'b0}};
      ret_addr_reg <= {PC_W{1'b0}};
      ctx_save_reg <= {CTX_W{1'b0}};
    end else begin
      int_take_reg <= take;
      push_reg     <= take;
      if (take) begin
        pc_vec_reg   <= vec_addr;
        ret_addr_reg <= pc_i;
        ctx_save_reg <= ctx_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      restore_reg    <= 1'b0;
      skip_valid_reg <= 1'b0;
      skip_reg       <= 1'b0;
      irq_reg        <= 1'b0;
      ack_reg        <= 1'b0;
      dat_reg        <= {DATA_W{1'b0}};
    end else begin
      restore_reg    <= boundary & return_from_int_instr_i;
      skip_valid_reg <= skip_fire;
      skip_reg       <= skip_fire & skip_hit;
      irq_reg        <= |(ev_stat_next & ev_mask_reg);
      ack_reg        <= ack_next;
      dat_reg        <= ack_next ? rd_mux : {DATA_W{1'b0}};
    end
  end

  assign int_take_o         = int_take_reg;
  assign program_counter_o  = pc_vec_reg;
  assign stack_push_o       = push_reg;
  assign call_stack_entry_o = ret_addr_reg;
  assign context_save_reg_o = ctx_save_reg;
  assign ctx_restore_o      = restore_reg;
  assign skip_valid_o       = skip_valid_reg;
  assign skip_o             = skip_reg;
  assign irq_o              = irq_reg;
  assign wb_ack_o           = ack_reg;
  assign wb_dat_o           = dat_reg;

endmodule

// File: int_unit_monitor.sv
// assertions on the sequencer side of the vectored interrupt unit
// assumes it is bound into vectored_interrupt_unit
`timescale 1ns/1ns
module int_unit_monitor
  import vectored_int_pkg::*;
(
  // clock and reset
  input wire logic             clk_i,
  input wire logic             srst_i,
  // sequencer requests
  input wire logic             instr_done_i,
  input wire logic             disable_all_instr_i,
  input wire logic             skip_test_i,
  input wire logic             return_from_int_instr_i,
  input wire logic [PC_W-1:0]  pc_i,
  input wire logic [CTX_W-1:0] ctx_i,
  // unit answers
  input wire logic             int_take_o,
  input wire logic [PC_W-1:0]  program_counter_o,
  input wire logic             stack_push_o,
  input wire logic [PC_W-1:0]  call_stack_entry_o,
  input wire logic [CTX_W-1:0] context_save_reg_o,
  input wire logic             ctx_restore_o,
  input wire logic             skip_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  take_at_boundary_a: assert property (
    int_take_o |-> $past(instr_done_i)) else $error("take off boundary");
  take_then_quiet_a: assert property (
    int_take_o |=> !int_take_o [*5]) else $error("take too soon after take");
  disable_blocks_a: assert property (
    instr_done_i && disable_all_instr_i |=> !int_take_o)
    else $error("take despite disable-all");
  vector_set_a: assert property (int_take_o |-> program_counter_o inside
    {14'h0080, 14'h0084, 14'h0086, 14'h0088}) else $error("bad vector");
  vector_page_a: assert property (
    int_take_o |-> program_counter_o[PC_W-1:OFF_W] == 7'h01)
    else $error("vector not in page one");
  push_pair_a: assert property (
    stack_push_o == int_take_o && !(stack_push_o && $past(stack_push_o)))
    else $error("push apart from take");
  context_saved_a: assert property (int_take_o |->
    call_stack_entry_o == $past(pc_i) && context_save_reg_o == $past(ctx_i))
    else $error("return address or context lost");
  skip_answer_a: assert property (
    instr_done_i && skip_test_i && !int_take_o |=> skip_valid_o)
    else $error("skip test unanswered");
  restore_pulse_a: assert property (
    instr_done_i && return_from_int_instr_i && !int_take_o |=> ctx_restore_o)
    else $error("no restore on return");

  cover property (int_take_o);
  cover property (skip_valid_o);
  cover property (ctx_restore_o);
endmodule

bind vectored_interrupt_unit int_unit_monitor i_int_unit_monitor (
  .clk_i, .srst_i, .instr_done_i, .disable_all_instr_i, .skip_test_i,
  .return_from_int_instr_i, .pc_i, .ctx_i, .int_take_o,
  .program_counter_o, .stack_push_o, .call_stack_entry_o,
  .context_save_reg_o, .ctx_restore_o, .skip_valid_o
);

// File: seq_model.sv
// instruction sequencer model: one instruction per issue call
// assumes the unit answers a boundary in the following cycle
`timescale 1ns/1ns
module seq_model
  import vectored_int_pkg::*;
(
  // clock and unit answers
  input  wire logic            clk_i,
  input  wire logic            int_take_i,
  input  wire logic [PC_W-1:0] vector_i,
  // boundary and qualifiers
  output logic                 instr_done_o,
  output logic                 enable_all_o,
  output logic                 disable_all_o,
  output logic                 skip_test_o,
  output logic [1:0]           skip_src_o,
  output logic                 return_o,
  output logic [PC_W-1:0]      pc_o
);
  logic [PC_W-1:0] pc_reg = 14'h0100;

  initial begin
    {instr_done_o, enable_all_o, disable_all_o, skip_test_o} = 4'h0;
    return_o = 1'b0;
    skip_src_o = 2'd0;
    pc_o = 14'h0000;
  end

  always @(posedge clk_i) begin
    if (int_take_i) begin
      pc_reg <= vector_i;
    end else if (instr_done_o) begin
      pc_reg <= pc_reg + 14'h0001;
    end
  end

  // trailing idle edge lets a vector load land before the next fetch
  task automatic issue(input logic [2:0] op, input logic [1:0] src);
    @(posedge clk_i);
    instr_done_o  <= 1'b1;
    enable_all_o  <= (op == 3'd1);
    disable_all_o <= (op == 3'd2);
    skip_test_o   <= (op == 3'd3);
    return_o      <= (op == 3'd4);
    skip_src_o    <= src;
    pc_o          <= pc_reg + 14'h0001;
    @(posedge clk_i);
    instr_done_o  <= 1'b0;
    pc_o          <= ~pc_o;
    @(posedge clk_i);
  endtask
endmodule

// File: test_vectored_interrupt_unit.sv
// self-checking bench for the vectored interrupt unit
// assumes seq_model as sequencer and the unit's register map
`timescale 1ns/1ns
module test_vectored_interrupt_unit
  import vectored_int_pkg::*;
;
  logic              clk_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [DATA_W-1:0] wb_dat_i, wb_dat_o;
  logic              ext_event_pin_i, supply_drop_pin_i, irq_o;
  logic [2:0]        tmr;
  logic              instr_done_i, enable_all_instr_i, disable_all_instr_i;
  logic              skip_test_i, return_from_int_instr_i, int_take_o;
  logic              skip_valid_o, skip_o;
  logic [1:0]        skip_src_i;
  logic [PC_W-1:0]   pc_i, program_counter_o;
  logic [CTX_W-1:0]  ctx_i;
  logic [DATA_W-1:0] exp_q[$];
  logic [31:0]       seed = 32'h0000_0063;
  logic [PC_W-1:0]   vec [4] = '{14'h0080, 14'h0084, 14'h0086, 14'h0088};
  int                errors = 0;
  int                checks = 0;

  vectored_interrupt_unit i_vectored_interrupt_unit (
    .clk_i, .srst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .ext_event_pin_i, .supply_drop_pin_i, .tmr_a_underflow_i(tmr[0]),
    .tmr_b_underflow_i(tmr[1]), .tmr_c_underflow_i(tmr[2]),
    .instr_done_i, .enable_all_instr_i, .disable_all_instr_i,
    .skip_test_i, .skip_src_i, .return_from_int_instr_i, .pc_i, .ctx_i,
    .int_take_o, .program_counter_o, .stack_push_o(),
    .call_stack_entry_o(), .context_save_reg_o(), .ctx_restore_o(),
    .skip_valid_o, .skip_o, .irq_o
  );
  seq_model i_seq_model (
    .clk_i, .int_take_i(int_take_o), .vector_i(program_counter_o),
    .instr_done_o(instr_done_i), .enable_all_o(enable_all_instr_i),
    .disable_all_o(disable_all_instr_i), .skip_test_o(skip_test_i),
    .skip_src_o(skip_src_i), .return_o(return_from_int_instr_i),
    .pc_o(pc_i)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // an answer with nothing expected compares against unknown and fails
  function automatic logic [DATA_W-1:0] nxt();
    if (exp_q.size() == 0) begin
      return 'x;
    end
    return exp_q.pop_front();
  endfunction

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wb_cycle(input logic we, input logic [ADDR_W-1:0] adr,
                          input logic [DATA_W-1:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk_i);
    // only the watchdog ends a wait that never sees ack
    while (wb_ack_o !== 1'b1) begin
      n++;
      @(posedge clk_i);
    end
    check_val(32'(n), 32'h0000_0001, "ack delay");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wb_read(input logic [ADDR_W-1:0] adr,
                         input logic [DATA_W-1:0] exp);
    exp_q.push_back(exp);
    wb_cycle(1'b0, adr, rnd());
  endtask

  task automatic instr(input logic [2:0] op, input logic [1:0] src = 2'd0);
    ctx_i <= CTX_W'(rnd());
    i_seq_model.issue(op, src);
  endtask

  task automatic fire(input logic [2:0] t, input logic p);
    tmr <= t;
    ext_event_pin_i <= p;
    @(posedge clk_i);
    tmr <= 3'b000;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic wrap_up();
    check_val(32'(exp_q.size()), 32'h0000_0000, "answers missing");
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (int_take_o === 1'b1) begin
      check_val({18'h0, program_counter_o}, nxt(), "vector");
    end
    if (skip_valid_o === 1'b1) begin
      check_val({31'h0, skip_o}, nxt(), "skip");
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      check_val(wb_dat_o, nxt(), "read");
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    $display("mismatch at %0t: run hung", $time);
    wrap_up();
  end

  initial begin
    {srst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {ext_event_pin_i, supply_drop_pin_i, tmr} = 5'h00;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    ctx_i = 24'h00_0000;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    wb_read(OFS_CTRL_LOW, 32'h0000_0000);
    supply_drop_pin_i <= 1'b1;
    fire(3'b000, 1'b0);
    wb_cycle(1'b1, OFS_FLAGS, 32'h0000_0010);
    wb_read(OFS_FLAGS, 32'h0000_0010);
    supply_drop_pin_i <= 1'b0;
    fire(3'b000, 1'b0);
    wb_cycle(1'b1, OFS_FLAGS, 32'h0000_0010);
    wb_read(OFS_FLAGS, 32'h0000_0000);
    wb_read(8'h40, 32'h0000_0000);
    wb_cycle(1'b1, OFS_CTRL_LOW, 32'h0000_000F);
    wb_cycle(1'b1, OFS_CTRL_HIGH, 32'h0000_0001);
    wb_read(OFS_CTRL_LOW, 32'h0000_000F);
    fire(3'b111, 1'b1);
    wb_read(OFS_FLAGS, 32'h0000_000F);
    instr(3'd0);
    for (int k = 0; k < 4; k++) begin
      instr(3'd1);
      instr(3'd0);
      exp_q.push_back({18'h0, vec[k]});
      instr(3'd0);
      wb_read(OFS_FLAGS, (32'h0000_000F << (k + 1)) & 32'h0000_000F);
    end
    instr(3'd4);
    fire(3'b001, 1'b1);
    instr(3'd1);
    instr(3'd0);
    instr(3'd2);
    instr(3'd0);
    exp_q.push_back(32'h0000_0000);
    instr(3'd3, 2'd1);
    wb_cycle(1'b1, OFS_CTRL_LOW, 32'h0000_0000);
    exp_q.push_back(32'h0000_0001);
    instr(3'd3, 2'd1);
    exp_q.push_back(32'h0000_0000);
    instr(3'd3, 2'd1);
    fire(3'b000, 1'b0);
    instr(3'd1);
    instr(3'd0);
    instr(3'd0);
    wb_cycle(1'b1, OFS_CTRL_LOW, 32'h0000_0001);
    exp_q.push_back({18'h0, vec[0]});
    instr(3'd0);
    check_val({31'h0, irq_o}, 32'h0000_0000, "irq masked");
    wb_cycle(1'b1, OFS_EV_MASK, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    check_val({31'h0, irq_o}, 32'h0000_0001, "irq raised");
    wb_cycle(1'b1, OFS_EV_STAT, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    check_val({31'h0, irq_o}, 32'h0000_0000, "irq cleared");
    wb_read(OFS_EV_STAT, 32'h0000_002F);
    wrap_up();
  end
endmodule
